// ---- shared/bgf_params.svh ----
// constants of the backlight group select and fade block
// assumes a 200 MHz core clock and byte-wide register access
`ifndef BGF_PARAMS_SVH
`define BGF_PARAMS_SVH

`define BGF_ADDR_GROUP_SEL   8'h11
`define BGF_ADDR_FADE_TIME   8'h12
`define BGF_GROUP_SEL_RST    8'h00
`define BGF_FADE_TIME_RST    8'h00
`define BGF_RD_UNMAPPED      8'h00
`define BGF_FO_MSB           7
`define BGF_FO_LSB           4
`define BGF_FI_MSB           3
`define BGF_FI_LSB           0
`define BGF_SINKS            8
`define BGF_CODE_ZERO        4'h0
`define BGF_CODE_FINE_MAX    4'hA
`define BGF_COARSE_MULT      6'h05
`define BGF_COARSE_OFFS      6'h28
`define BGF_LEVEL_ZERO       7'h00
`define BGF_LEVEL_ONE        7'h01
`define BGF_LEVEL_LOW_Q      7'h20
`define BGF_LEVEL_LOW_H      7'h40
`define BGF_WEIGHT_LIN       2'h1
`define BGF_WEIGHT_C10       2'h3
`define BGF_WEIGHT_C11       2'h2
`define BGF_FADE_UNIT_S      0.05
`define BGF_CLK_HZ           200.0e6
`define BGF_STEPS_FULL       127.0
`define BGF_CNT_ONE          32'h0000_0001
`define BGF_CNT_ZERO         32'h0000_0000

`endif

// ---- shared/bgf_pkg.sv ----
// types shared by the backlight group select and fade block
// assumes bgf_params.svh holds the numeric constants
package bgf_pkg;
   typedef logic [6:0] bgf_level_t;
   typedef logic [3:0] bgf_code_t;
   typedef logic [1:0] bgf_law_t;
   typedef enum logic [2:0] {
      BGF_ST_IDLE = 3'h1,
      BGF_ST_UP   = 3'h2,
      BGF_ST_DOWN = 3'h4
   } bgf_state_t;
endpackage : bgf_pkg

// ---- shared/bgf_ramp_if.sv ----
// carrier between the ramp controller and its step timer
// assumes one clock domain shared by both ends
`timescale 1ns/100ps
`default_nettype none
interface bgf_ramp_if;
   logic        run;
   logic [31:0] interval;
   logic        step;
   modport ctrl  (output run, output interval, input step);
   modport timer (input run, input interval, output step);
endinterface : bgf_ramp_if
`default_nettype wire

// ---- hw/bgf_ramp_timer.sv ----
// step timer: one pulse per ramp interval while a ramp runs
// assumes interval is at least one cycle whenever run is high
`timescale 1ns/100ps
`default_nettype none
`include "bgf_params.svh"
module bgf_ramp_timer (
   input  wire logic  i_clk,
   input  wire logic  i_rst_b,
   bgf_ramp_if.timer  rif
);
   import bgf_pkg::*;
   logic [31:0] count_reg;
   logic [31:0] count_next;
   logic [31:0] len_reg;
   logic [31:0] len_next;
   logic [31:0] len_eff;

   // length is latched per step so a rewrite never stretches a live step;
   // zero means nothing latched yet, so the live interval is used; this
   // keeps a stale zero-code length from before the ramp out of step one
   always_comb begin
      len_eff    = (len_reg == `BGF_CNT_ZERO) ? rif.interval : len_reg;
      count_next = count_reg + `BGF_CNT_ONE;
      len_next   = len_eff;
      rif.step   = 1'b0;
      if (!rif.run) begin
         count_next = `BGF_CNT_ZERO;
         len_next   = `BGF_CNT_ZERO;
      end else if (count_reg >= len_eff - `BGF_CNT_ONE) begin
         rif.step   = 1'b1;
         count_next = `BGF_CNT_ZERO;
         len_next   = `BGF_CNT_ZERO;
      end
   end

   // timer registers
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         count_reg <= `BGF_CNT_ZERO;
         len_reg   <= `BGF_CNT_ZERO;
      end else begin
         count_reg <= count_next;
         len_reg   <= len_next;
      end
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   a_len_held_step: assert property (
      (rif.run && !rif.step && len_reg != `BGF_CNT_ZERO) |=>
      $stable(len_reg))
      else $error("step length changed inside a step");
   a_step_spacing: assert property (
      rif.step |=> !rif.step || (rif.interval == `BGF_CNT_ONE))
      else $error("steps closer than the latched interval");
endmodule : bgf_ramp_timer
`default_nettype wire

// ---- hw/bgf_top.sv ----
// backlight group select and fade-time registers with the ramp engine
// assumes byte writes and reads arrive already decoded from the serial
// interface; enable, max current and transfer law come from outside
`timescale 1ns/100ps
`default_nettype none
`include "bgf_params.svh"
module bgf_top #(
   parameter int unsigned UNIT_STEP_CYC =
      int'($floor(`BGF_FADE_UNIT_S * `BGF_CLK_HZ / `BGF_STEPS_FULL))
) (
   input  wire logic            i_clk,
   input  wire logic            i_rst_b,
   input  wire logic            i_wr_en,
   input  wire logic            i_rd_en,
   input  wire logic [7:0]      i_addr,
   input  wire logic [7:0]      i_wr_data,
   output var  logic [7:0]      o_rd_data,
   input  wire logic            i_bl_enable,
   input  wire bgf_pkg::bgf_level_t i_max_current_code,
   input  wire bgf_pkg::bgf_law_t   i_ramp_transfer_law,
   output var  logic [7:0]      o_sink_independent,
   output var  logic [7:0]      o_sink_backlight,
   output var  bgf_pkg::bgf_level_t o_bl_level,
   output var  logic            o_ramping
);
   import bgf_pkg::*;

   logic [7:0] group_select_reg;
   logic [7:0] group_select_next;
   logic [7:0] fade_time_reg;
   logic [7:0] fade_time_next;
   logic [7:0] rd_data_reg;
   logic [7:0] rd_data_next;
   bgf_level_t level_reg;
   bgf_level_t level_next;
   bgf_state_t st_reg;
   bgf_state_t st_next;
   bgf_code_t  fade_out_code;
   bgf_code_t  fade_in_code;
   bgf_code_t  active_code;
   bgf_level_t target;
   logic [5:0] units;
   logic [1:0] weight;
   bgf_ramp_if rif ();

   assign fade_out_code = fade_time_reg[`BGF_FO_MSB:`BGF_FO_LSB];
   assign fade_in_code  = fade_time_reg[`BGF_FI_MSB:`BGF_FI_LSB];

   // register writes and read-back; unmapped reads give zero
   always_comb begin
      group_select_next = group_select_reg;
      fade_time_next    = fade_time_reg;
      rd_data_next      = rd_data_reg;
      if (i_wr_en && i_addr == `BGF_ADDR_GROUP_SEL)
         group_select_next = i_wr_data;
      if (i_wr_en && i_addr == `BGF_ADDR_FADE_TIME)
         fade_time_next = i_wr_data;
      if (i_rd_en) begin
         case (i_addr)
            `BGF_ADDR_GROUP_SEL: rd_data_next = group_select_reg;
            `BGF_ADDR_FADE_TIME: rd_data_next = fade_time_reg;
            default:             rd_data_next = `BGF_RD_UNMAPPED;
         endcase
      end
   end

   // register bank flops
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         group_select_reg <= `BGF_GROUP_SEL_RST;
         fade_time_reg    <= `BGF_FADE_TIME_RST;
         rd_data_reg      <= `BGF_RD_UNMAPPED;
      end else begin
         group_select_reg <= group_select_next;
         fade_time_reg    <= fade_time_next;
         rd_data_reg      <= rd_data_next;
      end
   end
   assign o_rd_data = rd_data_reg;

   // per-sink group steering, bit i drives sink i+1
   for (genvar gi = 0; gi < `BGF_SINKS; gi++) begin : g_sink
      assign o_sink_independent[gi] = group_select_reg[gi];
      assign o_sink_backlight[gi]   = ~group_select_reg[gi];
   end

   // target and which fade code applies; fade-in also covers a lowered
   // maximum while on, since the current-change fade is outside this block
   assign target      = i_bl_enable ? i_max_current_code
                                    : `BGF_LEVEL_ZERO;
   assign active_code = i_bl_enable ? fade_in_code
                                    : fade_out_code;

   // time table in 0.05 s units: code, or 5*code-40 above code 10
   always_comb begin
      if (active_code <= `BGF_CODE_FINE_MAX)
         units = {2'h0, active_code};
      else
         units = 6'(`BGF_COARSE_MULT * {2'h0, active_code})
                 - `BGF_COARSE_OFFS;
   end

   // cubic laws dwell longer on the low codes where the eye is sensitive
   always_comb begin
      case (i_ramp_transfer_law)
         2'h2:    weight = (level_reg < `BGF_LEVEL_LOW_Q) ?
                           `BGF_WEIGHT_C10 : `BGF_WEIGHT_LIN;
         2'h3:    weight = (level_reg < `BGF_LEVEL_LOW_H) ?
                           `BGF_WEIGHT_C11 : `BGF_WEIGHT_LIN;
         default: weight = `BGF_WEIGHT_LIN;
      endcase
   end

   // per-step interval: full time over 127, so short ramps end sooner
   assign rif.interval = 32'(UNIT_STEP_CYC) * 32'(units)
                         * 32'(weight);
   assign rif.run = (level_reg != target)
                    && (active_code != `BGF_CODE_ZERO);

   bgf_ramp_timer u_timer (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .rif     (rif.timer)
   );

   // ramp engine: one code per step, or a jump when the code is zero
   always_comb begin
      level_next = level_reg;
      st_next    = BGF_ST_IDLE;
      if (level_reg != target) begin
         if (active_code == `BGF_CODE_ZERO)
            level_next = target;
         else if (rif.step && level_reg < target)
            level_next = level_reg + `BGF_LEVEL_ONE;
         else if (rif.step)
            level_next = level_reg - `BGF_LEVEL_ONE;
      end
      case (st_reg)
         BGF_ST_IDLE,
         BGF_ST_UP,
         BGF_ST_DOWN: begin
            if (level_next < target)
               st_next = BGF_ST_UP;
            else if (level_next > target)
               st_next = BGF_ST_DOWN;
            else
               st_next = BGF_ST_IDLE;
         end
         default: st_next = BGF_ST_IDLE;
      endcase
   end

   // ramp state flops
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         level_reg <= `BGF_LEVEL_ZERO;
         st_reg    <= BGF_ST_IDLE;
      end else begin
         level_reg <= level_next;
         st_reg    <= st_next;
      end
   end
   assign o_bl_level = level_reg;
   assign o_ramping  = (st_reg != BGF_ST_IDLE);

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   a_sel_write_map: assert property (
      (i_wr_en && i_addr == `BGF_ADDR_GROUP_SEL) |=>
      (o_sink_independent == $past(i_wr_data))
      && (o_sink_backlight == ~$past(i_wr_data)))
      else $error("group select not applied to sinks");
   a_sel_bit_order: assert property (
      (i_wr_en && i_addr == `BGF_ADDR_GROUP_SEL) |=>
      (o_sink_independent[0] == $past(i_wr_data[0]))
      && (o_sink_independent[7] == $past(i_wr_data[7])))
      else $error("sink bit order wrong");
   a_fo_field_pos: assert property (
      (i_wr_en && i_addr == `BGF_ADDR_FADE_TIME) |=>
      (fade_out_code == $past(i_wr_data[7:4]))
      && (fade_in_code == $past(i_wr_data[3:0])))
      else $error("fade code fields misplaced");
   a_table_entries: assert property (
      (active_code == 4'hB |-> units == 6'h0F)
      and (active_code == 4'hF |-> units == 6'h23)
      and (active_code == 4'hA |-> units == 6'h0A))
      else $error("fade time table wrong");
   a_fo_zero_drop: assert property (
      (!i_bl_enable && fade_out_code == `BGF_CODE_ZERO) |=>
      (o_bl_level == `BGF_LEVEL_ZERO))
      else $error("zero fade-out did not drop at once");
   a_fi_zero_jump: assert property (
      (i_bl_enable && fade_in_code == `BGF_CODE_ZERO
       && $stable(i_max_current_code)) |=>
      (o_bl_level == $past(i_max_current_code)))
      else $error("zero fade-in did not jump to target");
   a_off_never_up: assert property (
      (!i_bl_enable && $past(!i_bl_enable)) |->
      (o_bl_level <= $past(o_bl_level)))
      else $error("level rose while off");
   a_one_per_step: assert property (
      ($past(active_code) != `BGF_CODE_ZERO && $changed(o_bl_level))
      |-> ($past(rif.step) && ((o_bl_level - $past(o_bl_level))
           == `BGF_LEVEL_ONE || ($past(o_bl_level) - o_bl_level)
           == `BGF_LEVEL_ONE)))
      else $error("ramp moved without a step or by more than one");
   a_cubic_weight: assert property (
      (i_ramp_transfer_law == 2'h2 && level_reg < `BGF_LEVEL_LOW_Q) |->
      (rif.interval == 32'(UNIT_STEP_CYC) * 32'(units) * 32'h0000_0003))
      else $error("cubic low-end weight not applied");
   a_on_reaches_max: assert property (
      (i_bl_enable && level_reg < i_max_current_code
       && rif.step) |=> (o_bl_level == $past(level_reg) + 7'h01))
      else $error("fade-in did not climb toward target");
endmodule : bgf_top
`default_nettype wire

// ---- verification/bgf_host_model.sv ----
// host register master model driving byte reads and writes
// assumes the design samples its bus on the rising edge of i_clk
`timescale 1ns/100ps
`default_nettype none
module bgf_host_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rd_data,
   output var  logic       o_wr_en,
   output var  logic       o_rd_en,
   output var  logic [7:0] o_addr,
   output var  logic [7:0] o_wr_data
);
   // bus idle from time zero
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr = 8'h00;
      o_wr_data = 8'h00;
   end

   // strobe held across exactly one rising edge
   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_wr_en = 1'b1;
      o_addr = a;
      o_wr_data = d;
      @(negedge i_clk);
      o_wr_en = 1'b0;
      o_wr_data = ~d; // stale data never lingers
   endtask : wr_byte

   // read data is registered, so it is taken one edge later
   task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_clk);
      o_rd_en = 1'b1;
      o_addr = a;
      @(negedge i_clk);
      o_rd_en = 1'b0;
      d = i_rd_data;
   endtask : rd_byte
endmodule : bgf_host_model
`default_nettype wire

// ---- verification/backlight_group_fade_config_tb_top.sv ----
// self-checking bench for the group select and fade-time block
// assumes a shortened step unit of 2 cycles to keep ramps brief
`timescale 1ns/100ps
`default_nettype none
`include "bgf_params.svh"
module backlight_group_fade_config_tb_top;
   import bgf_pkg::*;
   localparam int U = 2;
   logic        clk, rst_b, wr, rd, en;
   logic [7:0]  addr, wdat, rdat, s_ind, s_bl, rv;
   bgf_level_t  maxc, lvl;
   bgf_law_t    law;
   logic        ramping;
   int          err_total, samples_checked, cyc, n;
   typedef struct { logic [7:0] a, d, sink, fade; } row_t;
   row_t rows[5] = '{'{8'h11, 8'h01, 8'h01, 8'h00},
      '{8'h11, 8'h80, 8'h80, 8'h00}, '{8'h11, 8'hA5, 8'hA5, 8'h00},
      '{8'h12, 8'h3C, 8'hA5, 8'h3C}, '{8'h13, 8'hFF, 8'hA5, 8'h3C}};
   int w[4] = '{1, 1, 3, 2};

   bgf_host_model host (.i_clk(clk), .i_rd_data(rdat), .o_wr_en(wr),
      .o_rd_en(rd), .o_addr(addr), .o_wr_data(wdat));
   bgf_top #(.UNIT_STEP_CYC(U)) uut (.i_clk(clk), .i_rst_b(rst_b),
      .i_wr_en(wr), .i_rd_en(rd), .i_addr(addr), .i_wr_data(wdat),
      .o_rd_data(rdat), .i_bl_enable(en), .i_max_current_code(maxc),
      .i_ramp_transfer_law(law), .o_sink_independent(s_ind),
      .o_sink_backlight(s_bl), .o_bl_level(lvl), .o_ramping(ramping));

   // clock and a hang limit well above the expected run
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         results();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // step counts allow a few cycles of pipeline latency
   task automatic chk_n(input int lo);
      // counts past one byte are pinned to ff so they cannot alias lo
      chk(8'((n >= lo && n <= lo + 3) ? lo : ((n > 254) ? 255 : n)),
          8'(lo));
   endtask : chk_n
   // units of the full-scale time for a fade code
   function automatic int units(input int c);
      return (c <= 10) ? c : 5 * c - 40;
   endfunction : units
   // switch backlight and count edges until the level settles
   task automatic ramp(input logic on, input bgf_level_t tgt);
      @(negedge clk);
      en = on;
      n = 0;
      do begin
         @(negedge clk);
         n = n + 1;
      end while (lvl !== tgt && n < 2000);
      chk(8'(lvl), 8'(tgt));
   endtask : ramp
   task automatic results();
      $display("checked=%0d errors=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results

   // main sequence
   initial begin
      err_total = 0;
      samples_checked = 0;
      cyc = 0;
      rst_b = 1'b0;
      en = 1'b0;
      maxc = 7'h02;
      law = 2'b00;
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      chk(s_bl, 8'hFF);
      chk({lvl, ramping}, 8'h00);
      foreach (rows[i]) begin
         host.wr_byte(rows[i].a, rows[i].d);
         chk(s_ind, rows[i].sink);
         chk(s_bl, ~rows[i].sink);
         host.rd_byte(`BGF_ADDR_GROUP_SEL, rv);
         chk(rv, rows[i].sink);
         host.rd_byte(`BGF_ADDR_FADE_TIME, rv);
         chk(rv, rows[i].fade);
         host.rd_byte(8'h13, rv);
         chk(rv, 8'h00);
      end
      $display("register rows done");
      // every code both ways over a two-code ramp
      for (int c = 0; c < 16; c++) begin
         host.wr_byte(`BGF_ADDR_FADE_TIME, 8'(c * 17));
         ramp(1'b1, maxc);
         chk_n(2 * U * units(c));
         ramp(1'b0, 7'h00);
         chk_n(2 * U * units(c));
      end
      $display("fade code sweep done");
      // twice the span takes twice the time
      maxc = 7'h04;
      host.wr_byte(`BGF_ADDR_FADE_TIME, 8'h22);
      ramp(1'b1, maxc);
      chk_n(4 * U * 2);
      chk(8'(ramping), 8'h00);
      ramp(1'b0, 7'h00);
      maxc = 7'h02;
      for (int l = 0; l < 4; l++) begin
         law = 2'(l);
         host.wr_byte(`BGF_ADDR_FADE_TIME, 8'h01);
         ramp(1'b1, maxc);
         chk_n(2 * U * w[l]);
         host.wr_byte(`BGF_ADDR_FADE_TIME, 8'h00);
         ramp(1'b0, 7'h00);
      end
      law = 2'b00;
      $display("law and span done");
      // slow code rewritten mid-step: first step keeps its length
      host.wr_byte(`BGF_ADDR_FADE_TIME, 8'h0F);
      @(negedge clk);
      en = 1'b1;
      repeat (10) @(negedge clk);
      chk(8'(ramping), 8'h01);
      host.wr_byte(`BGF_ADDR_FADE_TIME, 8'h01);
      n = 12;
      while (lvl !== maxc && n < 2000) begin
         @(negedge clk);
         n = n + 1;
      end
      chk_n(U * 35 + U);
      $display("mid-ramp rewrite done");
      // reset again in mid-run
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      chk(s_bl, 8'hFF);
      host.rd_byte(`BGF_ADDR_FADE_TIME, rv);
      chk(rv, 8'h00);
      $display("second reset done");
      results();
   end
endmodule : backlight_group_fade_config_tb_top
`default_nettype wire
